// ---- common/isc_pkg.sv ----
// Purpose: Constants for the two-wire bus status and clock configuration block.
// Assumes: Byte addresses on an 8-bit register port with 32-bit data.
// Notes: All offsets are multiples of four.
// Operation
// R1 - Start-sent flag sets on START sent; clears on status-first read then data write.
// R2 - Second status bits 15:8 show the checksum computed when checksum is enabled.
// R3 - Bit 7 shows which own address matched; cleared on STOP, START, disable.
// R4 - Bit 6 sets on host header match in slave; cleared on STOP, START, disable.
// R5 - Bit 5 sets on default address match; cleared on STOP, START, disable.
// R6 - Bit 4 sets on general call address; cleared on STOP, START, disable.
// R7 - Bit 2 shows transmit; cleared on STOP, START, disable, arbitration loss.
// R8 - Bit 1 is bus busy while communication is active; cleared after STOP.
// R9 - Bit 0 master role; set on generated START, cleared on STOP, disable, loss.
// R10 - Clock config bit 15 selects standard or fast master speed.
// R11 - Standard speed: SCL high and low each last count times clock period.
// R12 - Fast, duty 0: high lasts count periods, low lasts twice that.
// R13 - Fast, duty 1: high nine times, low sixteen times the count.
// R14 - Software should pick clock multiples of 3 or 25 for accuracy.
// R15 - Software loads rise time plus one; field resets to 2.
// R16 - Status, clock config and rise-time registers take half-word and word accesses.
// R17 - Fast-plus enable allows 1 MHz using the fast period formulas.
// R18 - Address flag clears on status-first read then status-second read.
// R19 - Bus busy sets on any START detected on the bus.
package isc_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_STAT_FIRST = 8'h14;
  localparam logic [7:0] OFS_STAT_SECOND = 8'h18;
  localparam logic [7:0] OFS_CLK_CFG = 8'h1c;
  localparam logic [7:0] OFS_RISE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN = 8'h2c;
  localparam logic [7:0] OFS_FAST_PLUS = 8'h90;
  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PEC_EN = 1;
  localparam int CTRL_DUAL_EN = 2;
  localparam int CTRL_SMB_HOST_EN = 3;
  localparam int CTRL_GC_EN = 4;
  localparam int CTRL_START_REQ = 5;
  localparam int CTRL_STOP_REQ = 6;
  // Status fields
  localparam int SF_START_SENT = 0;
  localparam int SF_ADDR = 1;
  localparam int SF_ARB_LOST = 9;
  localparam int CFG_FAST = 15;
  localparam int CFG_DUTY = 14;
  localparam int FP_ENABLE = 0;
  // Interrupt event bits
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_ADDR = 2;
  localparam int IRQ_ARB = 3;
  localparam int IRQ_W = 4;
  localparam logic [6:0] RISE_RESET = 7'h02;
  localparam logic [15:0] CLK_CFG_RESET = 16'h0000;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [6:0] SMB_DEFAULT_ADDR = 7'h61;
  localparam logic [6:0] SMB_HOST_ADDR = 7'h08;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [15:0] DUTY_HIGH_MUL = 16'h0009;
  localparam logic [15:0] DUTY_LOW_MUL = 16'h0010;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b011,
    M_STOP_LOW = 3'b100,
    M_STOP_HIGH = 3'b101
  } isc_mstate_e;
endpackage

// ---- hdl/isc_i2c_status_clock.sv ----
// Purpose: Two-wire bus status, speed generation and rise-time registers.
// Assumes: SCL and SDA arrive asynchronously and are open-drain with separate enables.
// Notes: Master sends one byte from the data register, then clocks until stop.
`timescale 1ns/1ps
module isc_i2c_status_clock (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_half,
  output logic [31:0] o_rdata,
  output logic o_irq,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe
);
  isc_pkg::isc_mstate_e state_q;
  logic [6:0] ctrl_q;
  logic [14:0] own_addr_q;
  logic [7:0] data_q;
  logic [15:0] clk_cfg_q;
  logic [6:0] rise_q;
  logic fast_plus_q;
  logic [3:0] irq_stat_q, irq_en_q;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic start_sent_q, addr_flag_q, arb_lost_q;
  logic arm_data_q, arm_s2_q;
  logic dual_q, host_q, default_q, gc_q, tr_q, busy_q, master_q;
  logic [7:0] pec_q, sh_q;
  logic [7:0] pec_run_q;
  logic [3:0] sbit_q;
  logic addr_phase_q, ack_q;
  logic [15:0] cnt_q;
  logic [3:0] mbit_q;
  logic [7:0] tx_q;
  logic scl_oe_q, sda_oe_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic enable, wr_lo, start_det, stop_det, scl_rise, scl_fall;
  logic [7:0] byte_n;
  logic addr_ev, match_a, match_b, match_gc, match_def, match_host, any_match;
  logic fast, arb_ev, gen_start, phase_done;
  logic [15:0] scl_period_count, high_len, low_len, cur_len;
  logic [7:0] pec_n;
  logic [31:0] stat_first, stat_second, rd_word;
  logic [7:0] rd_ofs;

  assign enable = ctrl_q[isc_pkg::CTRL_ENABLE];
  // Half-word writes to the upper lanes only touch reserved bits
  assign wr_lo = i_wr && !(i_half && i_addr[1]); // [R16]
  assign rd_ofs = {i_addr[7:2], 2'b00}; // [R16]

  // Two-flop synchronisers; edge logic compares the second stage with its delayed copy
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;

  // Speed selection: fast-plus reuses the fast formulas
  assign fast = clk_cfg_q[isc_pkg::CFG_FAST] || fast_plus_q; // [R10] [R17]
  assign scl_period_count = {4'h0, clk_cfg_q[11:0]};
  always_comb begin
    if (!fast) begin
      high_len = scl_period_count; // [R11]
      low_len = scl_period_count; // [R11]
    end else if (!clk_cfg_q[isc_pkg::CFG_DUTY]) begin
      high_len = scl_period_count; // [R12]
      low_len = {scl_period_count[14:0], 1'b0}; // [R12]
    end else begin
      high_len = 16'(scl_period_count * isc_pkg::DUTY_HIGH_MUL); // [R13]
      low_len = 16'(scl_period_count * isc_pkg::DUTY_LOW_MUL); // [R13]
    end
  end
  assign cur_len = (state_q == isc_pkg::M_LOW || state_q == isc_pkg::M_STOP_LOW) ?
                   low_len : high_len;
  // A zero count still gives one cycle per phase
  assign phase_done = (16'(cnt_q + 16'h0001) >= cur_len);

  // Arbitration: we released SDA for a one but the line reads low
  assign arb_ev = (state_q == isc_pkg::M_HIGH) && scl_s2 && !sda_oe_q && !sda_s2 &&
                  (mbit_q < isc_pkg::ACK_BIT);
  // Gated by enable so a disable at the end of START leaves no master role behind
  assign gen_start = enable && (state_q == isc_pkg::M_START) && phase_done;

  // Master SCL/SDA generator
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= isc_pkg::M_IDLE;
      cnt_q <= 16'h0000;
      mbit_q <= 4'h0;
      tx_q <= 8'h00;
    end else if (!enable || arb_ev) begin
      state_q <= isc_pkg::M_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        isc_pkg::M_IDLE: begin
          cnt_q <= 16'h0000;
          if (ctrl_q[isc_pkg::CTRL_START_REQ] && !busy_q) begin
            state_q <= isc_pkg::M_START;
            tx_q <= data_q;
          end
        end
        isc_pkg::M_START: begin
          cnt_q <= phase_done ? 16'h0000 : 16'(cnt_q + 16'h0001);
          if (phase_done) begin
            state_q <= isc_pkg::M_LOW;
            mbit_q <= 4'h0;
          end
        end
        isc_pkg::M_LOW: begin
          cnt_q <= phase_done ? 16'h0000 : 16'(cnt_q + 16'h0001);
          if (phase_done) begin
            state_q <= isc_pkg::M_HIGH;
          end
        end
        isc_pkg::M_HIGH: begin
          // Holding off the count while SCL is low honours slave stretching
          if (scl_s2) begin
            cnt_q <= phase_done ? 16'h0000 : 16'(cnt_q + 16'h0001);
          end
          if (scl_s2 && phase_done) begin
            mbit_q <= (mbit_q == isc_pkg::ACK_BIT) ? 4'h0 : 4'(mbit_q + 4'h1);
            if (mbit_q < isc_pkg::ACK_BIT) begin
              tx_q <= {tx_q[6:0], 1'b1};
            end
            state_q <= (mbit_q == isc_pkg::ACK_BIT && ctrl_q[isc_pkg::CTRL_STOP_REQ]) ?
                       isc_pkg::M_STOP_LOW : isc_pkg::M_LOW;
          end
        end
        isc_pkg::M_STOP_LOW: begin
          cnt_q <= phase_done ? 16'h0000 : 16'(cnt_q + 16'h0001);
          if (phase_done) begin
            state_q <= isc_pkg::M_STOP_HIGH;
          end
        end
        isc_pkg::M_STOP_HIGH: begin
          cnt_q <= phase_done ? 16'h0000 : 16'(cnt_q + 16'h0001);
          if (phase_done) begin
            state_q <= isc_pkg::M_IDLE;
          end
        end
        default: begin
          state_q <= isc_pkg::M_IDLE;
        end
      endcase
    end
  end

  // Pin drive: low only, enables come from the master state, the data bit and the slave ack
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= enable && !arb_ev && (state_q == isc_pkg::M_LOW ||
                  state_q == isc_pkg::M_STOP_LOW);
      sda_oe_q <= enable && !arb_ev && (state_q == isc_pkg::M_START ||
                  state_q == isc_pkg::M_STOP_LOW || state_q == isc_pkg::M_STOP_HIGH ||
                  ((state_q == isc_pkg::M_LOW || state_q == isc_pkg::M_HIGH) &&
                   mbit_q < isc_pkg::ACK_BIT && !tx_q[7]) || ack_q);
    end
  end

  // Slave address capture
  assign byte_n = {sh_q[6:0], sda_s2};
  assign addr_ev = enable && !master_q && addr_phase_q && scl_rise && (sbit_q == 4'h7);
  assign match_a = (byte_n[7:1] == own_addr_q[6:0]);
  assign match_b = ctrl_q[isc_pkg::CTRL_DUAL_EN] && (byte_n[7:1] == own_addr_q[14:8]);
  assign match_gc = ctrl_q[isc_pkg::CTRL_GC_EN] && (byte_n[7:1] == isc_pkg::GEN_CALL_ADDR);
  assign match_def = ctrl_q[isc_pkg::CTRL_SMB_HOST_EN] &&
                     (byte_n[7:1] == isc_pkg::SMB_DEFAULT_ADDR);
  assign match_host = ctrl_q[isc_pkg::CTRL_SMB_HOST_EN] &&
                      (byte_n[7:1] == isc_pkg::SMB_HOST_ADDR);
  assign any_match = match_a || match_b || match_gc || match_def || match_host;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_q <= 8'h00;
      sbit_q <= 4'h0;
      addr_phase_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (start_det || stop_det || !enable) begin
      sbit_q <= 4'h0;
      addr_phase_q <= start_det && enable;
      ack_q <= 1'b0;
    end else begin
      if (scl_rise) begin
        sh_q <= byte_n;
        sbit_q <= (sbit_q == isc_pkg::ACK_BIT) ? 4'h0 : 4'(sbit_q + 4'h1);
        if (sbit_q == isc_pkg::ACK_BIT) begin
          addr_phase_q <= 1'b0;
        end
      end
      if (addr_ev && any_match) begin
        ack_q <= 1'b1;
      end else if (scl_fall && sbit_q == 4'h0) begin
        ack_q <= 1'b0;
      end
    end
  end

  // Checksum over every data bit since START, CRC-8 style
  assign pec_n = {pec_run_q[6:0], 1'b0} ^
                 ((pec_run_q[7] ^ sda_s2) ? isc_pkg::CRC_POLY : 8'h00);
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pec_q <= 8'h00;
      pec_run_q <= 8'h00;
    end else if (!ctrl_q[isc_pkg::CTRL_PEC_EN] || start_det) begin
      pec_q <= 8'h00;
      pec_run_q <= 8'h00;
    end else if (scl_rise && sbit_q != isc_pkg::ACK_BIT) begin
      pec_run_q <= pec_n;
      // Only whole bytes are shown, so the SCL rise of a STOP adds no stray bit
      if (sbit_q == 4'h7) begin
        pec_q <= pec_n; // [R2]
      end
    end
  end

  // Second-status flags
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      dual_q <= 1'b0;
      host_q <= 1'b0;
      default_q <= 1'b0;
      gc_q <= 1'b0;
    end else if (start_det || stop_det || !enable) begin
      dual_q <= 1'b0; // [R3]
      host_q <= 1'b0; // [R4]
      default_q <= 1'b0; // [R5]
      gc_q <= 1'b0; // [R6]
    end else if (addr_ev) begin
      dual_q <= match_b && !match_a; // [R3]
      host_q <= match_host; // [R4]
      default_q <= match_def; // [R5]
      gc_q <= match_gc; // [R6]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      tr_q <= 1'b0;
      master_q <= 1'b0;
    end else if (gen_start) begin
      tr_q <= 1'b1;
      master_q <= 1'b1; // [R9]
    end else if (start_det || stop_det || !enable || arb_ev) begin
      tr_q <= 1'b0; // [R7]
      master_q <= master_q && start_det && enable && !arb_ev; // [R9]
    end else if (addr_ev && any_match) begin
      tr_q <= byte_n[0]; // [R7]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1; // [R19]
    end else if (stop_det) begin
      busy_q <= 1'b0; // [R8]
    end
  end

  // First-status flags: the set wins over a software clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      start_sent_q <= 1'b0;
      addr_flag_q <= 1'b0;
      arb_lost_q <= 1'b0;
      arm_data_q <= 1'b0;
      arm_s2_q <= 1'b0;
    end else begin
      if (gen_start) begin
        start_sent_q <= 1'b1; // [R1]
      end else if (arm_data_q && wr_lo && rd_ofs == isc_pkg::OFS_DATA) begin
        start_sent_q <= 1'b0; // [R1]
      end
      if ((addr_ev && any_match) || (state_q == isc_pkg::M_HIGH && scl_s2 &&
          phase_done && mbit_q == isc_pkg::ACK_BIT && !sda_s2)) begin
        addr_flag_q <= 1'b1;
      end else if (arm_s2_q && i_rd && rd_ofs == isc_pkg::OFS_STAT_SECOND) begin
        addr_flag_q <= 1'b0; // [R18]
      end
      if (arb_ev) begin
        arb_lost_q <= 1'b1;
      end else if (wr_lo && rd_ofs == isc_pkg::OFS_STAT_FIRST &&
                   !i_wdata[isc_pkg::SF_ARB_LOST]) begin
        arb_lost_q <= 1'b0;
      end
      if (i_rd && rd_ofs == isc_pkg::OFS_STAT_FIRST) begin
        arm_data_q <= 1'b1;
        arm_s2_q <= 1'b1;
      end else begin
        if (wr_lo && rd_ofs == isc_pkg::OFS_DATA) begin
          arm_data_q <= 1'b0;
        end
        if (i_rd && rd_ofs == isc_pkg::OFS_STAT_SECOND) begin
          arm_s2_q <= 1'b0;
        end
      end
    end
  end

  // Software-written registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= 7'h00;
      own_addr_q <= 15'h0000;
      data_q <= 8'h00;
      clk_cfg_q <= isc_pkg::CLK_CFG_RESET;
      rise_q <= isc_pkg::RISE_RESET; // [R15]
      fast_plus_q <= 1'b0;
      irq_en_q <= 4'h0;
    end else begin
      if (gen_start) begin
        ctrl_q[isc_pkg::CTRL_START_REQ] <= 1'b0;
      end
      if (state_q == isc_pkg::M_STOP_HIGH && phase_done) begin
        ctrl_q[isc_pkg::CTRL_STOP_REQ] <= 1'b0;
      end
      if (wr_lo) begin
        unique case (rd_ofs)
          isc_pkg::OFS_CTRL: ctrl_q <= i_wdata[6:0];
          isc_pkg::OFS_OWN_ADDR: own_addr_q <= i_wdata[14:0];
          isc_pkg::OFS_DATA: data_q <= i_wdata[7:0];
          isc_pkg::OFS_CLK_CFG: clk_cfg_q <= {i_wdata[15:14], 2'b00, i_wdata[11:0]}; // [R16]
          isc_pkg::OFS_RISE: rise_q <= i_wdata[6:0]; // [R16]
          isc_pkg::OFS_FAST_PLUS: fast_plus_q <= i_wdata[isc_pkg::FP_ENABLE]; // [R17]
          isc_pkg::OFS_IRQ_EN: irq_en_q <= i_wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky event bits; an event beats a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_lo && rd_ofs == isc_pkg::OFS_IRQ_CLR) ?
                    i_wdata[3:0] : 4'h0)) |
                    {arb_ev, addr_ev && any_match, stop_det, start_det};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read path
  assign stat_first = {22'h0, arb_lost_q, 7'h0, addr_flag_q, start_sent_q};
  assign stat_second = {16'h0, pec_q, dual_q, host_q, default_q, gc_q, 1'b0, tr_q, busy_q,
                        master_q}; // [R2] [R8]
  always_comb begin
    unique case (rd_ofs)
      isc_pkg::OFS_CTRL: rd_word = {25'h0, ctrl_q};
      isc_pkg::OFS_OWN_ADDR: rd_word = {17'h0, own_addr_q};
      isc_pkg::OFS_DATA: rd_word = {24'h0, data_q};
      isc_pkg::OFS_STAT_FIRST: rd_word = stat_first;
      isc_pkg::OFS_STAT_SECOND: rd_word = stat_second;
      isc_pkg::OFS_CLK_CFG: rd_word = {16'h0, clk_cfg_q};
      isc_pkg::OFS_RISE: rd_word = {25'h0, rise_q};
      isc_pkg::OFS_IRQ_STAT: rd_word = {28'h0, irq_stat_q};
      isc_pkg::OFS_IRQ_EN: rd_word = {28'h0, irq_en_q};
      isc_pkg::OFS_FAST_PLUS: rd_word = {31'h0, fast_plus_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      // Upper half-word read shifts the high lanes down
      rdata_q <= (i_half && i_addr[1]) ? {16'h0, rd_word[31:16]} : rd_word; // [R16]
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_scl_oe = scl_oe_q;
  assign o_sda_oe = sda_oe_q;
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;

  busy_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R19]
    start_det |=> busy_q) else $error("busy flag not set on START");
  busy_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R8]
    stop_det && !start_det |=> !busy_q) else $error("busy flag not cleared on STOP");
  master_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R9]
    gen_start |=> master_q && start_sent_q) else $error("master role not set on START");
  arb_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R7]
    arb_ev |=> !master_q && !tr_q && state_q == isc_pkg::M_IDLE)
    else $error("arbitration loss did not drop roles");
  std_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R11]
    !fast |-> high_len == scl_period_count && low_len == scl_period_count) else $error("standard period wrong");
  fast_duty0_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R12]
    fast && !clk_cfg_q[isc_pkg::CFG_DUTY] |-> low_len == 16'(high_len * 16'h0002))
    else $error("fast low phase not twice high");
  fast_duty1_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R13]
    fast && clk_cfg_q[isc_pkg::CFG_DUTY] |-> 16'(low_len * 16'h0009) ==
    16'(high_len * 16'h0010)) else $error("fast duty ratio not 16 to 9");
  low_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R11]
    (state_q == isc_pkg::M_LOW && enable && !arb_ev) ##1 (state_q != isc_pkg::M_LOW)
    |-> 16'($past(cnt_q) + 16'h0001) >= $past(low_len)) else $error("SCL low too short");
  sent_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R1]
    arm_data_q && wr_lo && rd_ofs == isc_pkg::OFS_DATA && !gen_start |=> !start_sent_q)
    else $error("start-sent flag not cleared");
  flags_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R3]
    !enable |=> !dual_q && !host_q && !default_q && !gc_q && !master_q)
    else $error("flags not cleared on disable");
  gen_call_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R6]
    addr_ev && match_gc && !start_det && !stop_det |=> gc_q ##1 (gc_q ||
    $past(start_det || stop_det || !enable))) else $error("general call flag not set");
  irq_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ##1 o_irq == $past(|(irq_stat_q & irq_en_q))) else $error("interrupt level wrong");
endmodule

// ---- testbench/isc_bus_partner.sv ----
// Purpose: Far side of the two-wire bus: acks controller bytes, acts as second master.
// Assumes: Both lines have pull-ups; 160 ns link clock while this side masters.
// Notes: Released lines read high through the pull-up, never the last driven value.
`timescale 1ns/1ps
module isc_bus_partner (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  logic mst = 1'b0;
  int nb = 0;
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  always @(negedge i_sda) begin
    if (i_scl) nb = 0;
  end
  // Ack only the ninth bit, so the controller can run a whole byte
  always @(negedge i_scl) begin
    if (!mst) begin
      nb = nb + 1;
      o_sda_oe = (nb == 9);
    end
  end
  task automatic frame(input logic [7:0] b);
    mst = 1'b1;
    o_sda_oe = 1'b1;
    #80;
    for (int i = 0; i < 9; i++) begin
      o_scl_oe = 1'b1;
      #40 o_sda_oe = (i < 8) ? ~b[7 - i] : 1'b0;
      #40 o_scl_oe = 1'b0;
      #80;
    end
    o_scl_oe = 1'b1;
  endtask
  // Holds SDA low as a rival master would; the ack logic is muted meanwhile
  task automatic pull(input logic on);
    mst = on;
    o_sda_oe = on;
  endtask
  task automatic stop();
    #40 o_sda_oe = 1'b1;
    #40 o_scl_oe = 1'b0;
    #80 o_sda_oe = 1'b0;
    #80 mst = 1'b0;
  endtask
endmodule

// ---- testbench/isc_i2c_status_clock_test.sv ----
// Purpose: Self-checking bench for the status and clock configuration block.
// Assumes: Partner model on the far side of the bus; no random stimulus.
// Notes: SCL high time is checked within a window for the line synchroniser.
`timescale 1ns/1ps
module isc_i2c_status_clock_test;
  logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_half = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, v;
  logic o_irq, scl_oe, sda_oe, p_scl_oe, p_sda_oe, scl_o, sda_o;
  wire scl = ~(scl_oe | p_scl_oe);
  wire sda = ~(sda_oe | p_sda_oe);
  int error_cnt = 0, n_compared = 0, k, lo, hi;
  typedef struct {logic [7:0] a; logic h; logic [31:0] w; logic [31:0] e;} isc_row_s;
  isc_row_s rows[7] = '{'{8'h1c, 1'b0, 32'hc123, 32'hc123}, '{8'h20, 1'b0, 32'h7f, 32'h7f},
    '{8'h18, 1'b0, 32'hffff, 32'h0}, '{8'h90, 1'b0, 32'h1, 32'h1},
    '{8'h1e, 1'b1, 32'h5555, 32'h0}, '{8'h1c, 1'b1, 32'h4007, 32'h4007},
    '{8'h40, 1'b0, 32'hffffffff, 32'h0}};
  // Duty-one row runs on 50 MHz, a multiple of 25, for an exact ratio
  logic [15:0] cfg[4] = '{16'h0004, 16'h8004, 16'hc001, 16'h0004};
  int lw[4] = '{4, 8, 16, 8};
  int hw[4] = '{4, 4, 9, 4};
  logic [7:0] sb[4] = '{8'h00, 8'hc2, 8'h10, 8'h68};
  logic [7:0] ctl[4] = '{8'h11, 8'h09, 8'h09, 8'h05};
  logic [7:0] ex[4] = '{8'h10, 8'h20, 8'h40, 8'h80};
  isc_i2c_status_clock dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_half(i_half), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda),
    .o_sda_o(sda_o),
    .o_sda_oe(sda_oe));
  isc_bus_partner partner_u (.i_scl(scl), .i_sda(sda), .o_scl_oe(p_scl_oe),
    .o_sda_oe(p_sda_oe));
  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tmo();
    if (k > 3000) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic h = 1'b0);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    i_half <= h;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic h = 1'b0);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    i_half <= h;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic idle();
    k = 0;
    do begin
      rd(8'h18, v);
      k++;
      tmo();
    end while (v[1] !== 1'b0);
  endtask
  function automatic logic [7:0] crc(input logic [7:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int j = 7; j >= 0; j--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[j]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, rows[i].h);
      rd(rows[i].a, v, rows[i].h);
      chk(v, rows[i].e);
    end
    i_rstn <= 1'b0;
    @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    rd(8'h20, v);
    chk(v, 32'h2);
    rd(8'h1c, v);
    chk(v, 32'h0);
    rd(8'h18, v);
    chk(v, 32'h0);
    wr(8'h2c, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(8'h90, {31'h0, i == 3});
      wr(8'h1c, {16'h0, cfg[i]});
      wr(8'h10, 32'ha4);
      wr(8'h00, 32'h23);
      for (k = 0; !scl_oe; k++) begin
        @(posedge i_clk_sys);
        #1 tmo();
      end
      for (lo = 0; scl_oe && lo < 999; lo++) @(posedge i_clk_sys) #1;
      for (hi = 0; !scl_oe && hi < 999; hi++) @(posedge i_clk_sys) #1;
      chk(lo, lw[i]);
      chk(hi >= hw[i] && hi <= hw[i] + 3, 1'b1);
      rd(8'h18, v);
      chk(v & 32'h7, 32'h7);
      rd(8'h14, v);
      chk(v & 32'h1, 32'h1);
      wr(8'h10, 32'ha4);
      rd(8'h14, v);
      chk(v & 32'h1, 32'h0);
      wr(8'h00, 32'h43);
      idle();
      rd(8'h18, v);
      chk(v, {16'h0, crc(8'ha4), 8'h00});
    end
    wr(8'h00, 32'h21);
    for (k = 0; !scl_oe; k++) begin
      @(posedge i_clk_sys);
      #1 tmo();
    end
    partner_u.pull(1'b1);
    repeat (40) @(posedge i_clk_sys);
    chk({scl_oe, sda_oe, scl_o, sda_o}, 4'h0);
    partner_u.pull(1'b0);
    idle();
    rd(8'h14, v);
    chk(v & 32'h200, 32'h200);
    rd(8'h18, v);
    chk(v & 32'h7, 32'h0);
    chk(o_irq, 1'b1);
    rd(8'h24, v);
    chk(v & 32'h3, 32'h3);
    wr(8'h2c, 32'h0);
    @(posedge i_clk_sys);
    #1 chk(o_irq, 1'b0);
    wr(8'h2c, 32'h3);
    wr(8'h28, 32'hf);
    rd(8'h24, v);
    chk(v, 32'h0);
    chk(o_irq, 1'b0);
    wr(8'h08, 32'h3412);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {24'h0, ctl[i]});
      partner_u.frame(sb[i]);
      rd(8'h14, v);
      chk(v & 32'h2, 32'h2);
      rd(8'h18, v);
      chk(v & 32'hf7, 32'h2 | ex[i]);
      rd(8'h14, v);
      chk(v & 32'h2, 32'h0);
      partner_u.stop();
      idle();
      rd(8'h18, v);
      chk(v & 32'hff, 32'h0);
    end
    wr(8'h00, 32'h11);
    partner_u.frame(8'h00);
    wr(8'h00, 32'h0);
    rd(8'h18, v);
    chk(v & 32'h10, 32'h0);
    partner_u.stop();
    idle();
    stop_test();
  end
endmodule
